//--- cache_id_consts.svh
/*
  Constants for the cache identification register bank: coprocessor
  access codes, fixed field values, reset values and cache geometry.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef CACHE_ID_CONSTS_SVH
`define CACHE_ID_CONSTS_SVH

`define CID_OP1_ID 3'h1
`define CID_OP1_SEL 3'h2
`define CID_CRN 4'h0
`define CID_CRM 4'h0
`define CID_OP2_GEOM 3'h0
`define CID_OP2_HIER 3'h1
`define CID_OP2_AUX 3'h7
`define CID_OP2_SEL 3'h0

`define CID_SUPPORT_ICACHE 4'h2
`define CID_SUPPORT_DCACHE 4'h7
`define CID_ASSOC_CODE 10'h003
`define CID_LINE_CODE 3'h1
`define CID_WAYS 4
`define CID_LINE_BYTES 32
`define CID_SETS_16K 15'h007F
`define CID_SETS_32K 15'h00FF
`define CID_SETS_64K 15'h01FF

`define CID_LEVEL_ONE 3'h1
`define CID_L1_SPLIT 3'h3
`define CID_NO_CACHE 3'h0
`define CID_AUX_VALUE 32'h0000_0000
`define CID_LEVEL_FIELD 3'h0
`define CID_SEL_RESET 1'b0
`define CID_RDATA_IDLE 32'h0000_0000

`endif

//--- cache_id_pkg.sv
/*
  Types for the cache identification register bank: coprocessor request
  and answer carriers and the field layouts of the three registers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package cache_id_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic priv;
    logic nonsecure;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic [31:0] wdata;
  } cp_req_t;

  typedef struct packed {
    logic ack;
    logic refused;
    logic [31:0] rdata;
  } cp_rsp_t;

  typedef struct packed {
    logic write_through_support;
    logic write_back_support;
    logic read_alloc_support;
    logic write_alloc_support;
    logic [14:0] set_count;
    logic [9:0] assoc_ways;
    logic [2:0] line_length;
  } geometry_t;

  typedef struct packed {
    logic [1:0] spare;
    logic [2:0] unification_level;
    logic [2:0] coherency_level;
    logic [2:0] inner_share_unify_level;
    logic [5:0][2:0] upper_level_type;
    logic [2:0] l1_type;
  } hierarchy_t;

  typedef struct packed {
    logic [27:0] spare;
    logic [2:0] level;
    logic icache_not_dcache;
  } picker_t;

endpackage
`default_nettype wire

//--- cache_id_regs.sv
/*
  Cache identification register bank: geometry, hierarchy and auxiliary
  identification registers plus the banked cache picker register, all
  reached by coprocessor moves. Assumes the core presents one request
  per cycle at most and samples the registered answer one cycle later.
*/
`default_nettype none
`include "cache_id_consts.svh"

module cache_id_regs #(
  parameter int CACHE_SIZE_KB = 32
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire cache_id_pkg::cp_req_t cp_req,
  output var cache_id_pkg::cp_rsp_t cp_rsp
);

  localparam int SETS = CACHE_SIZE_KB * 1024 / (`CID_WAYS * `CID_LINE_BYTES);

  // Decode
  logic base_id;
  logic base_sel;
  logic hit_geom;
  logic hit_hier;
  logic hit_aux;
  logic hit_sel;
  logic mapped;
  logic ro_write;
  logic allowed;
  logic sel_wr;
  logic sec_wr;
  logic ns_wr;

  assign base_id = cp_req.opc1 == `CID_OP1_ID && cp_req.crn == `CID_CRN
                   && cp_req.crm == `CID_CRM;
  assign base_sel = cp_req.opc1 == `CID_OP1_SEL && cp_req.crn == `CID_CRN
                    && cp_req.crm == `CID_CRM;
  assign hit_geom = base_id && cp_req.opc2 == `CID_OP2_GEOM;
  assign hit_hier = base_id && cp_req.opc2 == `CID_OP2_HIER;
  assign hit_aux = base_id && cp_req.opc2 == `CID_OP2_AUX;
  assign hit_sel = base_sel && cp_req.opc2 == `CID_OP2_SEL;
  assign mapped = hit_geom || hit_hier || hit_aux || hit_sel;
  // The identification registers are read-only; a write to them is refused
  assign ro_write = cp_req.write && !hit_sel;
  assign allowed = cp_req.priv && mapped && !ro_write;
  assign sel_wr = cp_req.valid && allowed && cp_req.write && hit_sel;
  assign sec_wr = sel_wr && !cp_req.nonsecure;
  assign ns_wr = sel_wr && cp_req.nonsecure;

  // Banked picker copies
  logic sec_icache;
  logic ns_icache;
  logic cur_icache;

  cache_sel_bank u_sec_bank (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(sec_wr),
    .wr_bit(cp_req.wdata[0]),
    .icache_not_dcache(sec_icache)
  );

  cache_sel_bank u_ns_bank (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(ns_wr),
    .wr_bit(cp_req.wdata[0]),
    .icache_not_dcache(ns_icache)
  );

  // Each state sees only its own copy
  assign cur_icache = cp_req.nonsecure ? ns_icache : sec_icache;

  // Register contents
  cache_id_pkg::geometry_t geom;
  cache_id_pkg::hierarchy_t hier;
  cache_id_pkg::picker_t picker;

  always_comb begin
    geom = '0;
    // Support pattern follows the picker of the requesting state
    {geom.write_through_support, geom.write_back_support, geom.read_alloc_support,
     geom.write_alloc_support} = cur_icache ? `CID_SUPPORT_ICACHE
                                            : `CID_SUPPORT_DCACHE;
    // Both caches share one configured size
    geom.set_count = 15'(SETS - 1);
    geom.assoc_ways = `CID_ASSOC_CODE;
    geom.line_length = `CID_LINE_CODE;
  end

  always_comb begin
    hier = '0;
    hier.unification_level = `CID_LEVEL_ONE;
    hier.coherency_level = `CID_LEVEL_ONE;
    hier.inner_share_unify_level = `CID_LEVEL_ONE;
    for (int i = 0; i < 6; i++) begin
      hier.upper_level_type[i] = `CID_NO_CACHE;
    end
    hier.l1_type = `CID_L1_SPLIT;
  end

  always_comb begin
    picker = '0;
    // Only one cache level exists, so the level field never stores
    picker.level = `CID_LEVEL_FIELD;
    picker.icache_not_dcache = cur_icache;
  end

  // Read mux: hierarchy and auxiliary ignore the security state; geometry follows it
  logic [31:0] rdata_nxt;

  always_comb begin
    rdata_nxt = `CID_RDATA_IDLE;
    if (allowed && !cp_req.write) begin
      if (hit_geom) begin
        rdata_nxt = geom;
      end else if (hit_hier) begin
        rdata_nxt = hier;
      end else if (hit_aux) begin
        rdata_nxt = `CID_AUX_VALUE;
      end else if (hit_sel) begin
        rdata_nxt = picker;
      end else begin
        rdata_nxt = `CID_RDATA_IDLE;
      end
    end
  end

  // Answer, one cycle after the request
  logic ack_r;
  logic refused_r;
  logic [31:0] rdata_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      ack_r <= cp_req.valid;
      refused_r <= cp_req.valid && !allowed;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_r <= `CID_RDATA_IDLE;
    end else if (cp_req.valid) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign cp_rsp.ack = ack_r;
  assign cp_rsp.refused = refused_r;
  assign cp_rsp.rdata = rdata_r;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic [14:0] sets_expect;
  always_comb begin
    case (CACHE_SIZE_KB)
      16: sets_expect = `CID_SETS_16K;
      32: sets_expect = `CID_SETS_32K;
      64: sets_expect = `CID_SETS_64K;
      default: sets_expect = 15'(SETS - 1);
    endcase
  end

  sequence s_read_geom;
    cp_req.valid && cp_req.priv && !cp_req.write && hit_geom;
  endsequence

  sequence s_write_sel(bit b);
    cp_req.valid && cp_req.priv && cp_req.write && hit_sel && cp_req.wdata[0] == b;
  endsequence

  AST_UNPRIV_REFUSED: assert property (
    cp_req.valid && !cp_req.priv |=> cp_rsp.ack && cp_rsp.refused
                                     && cp_rsp.rdata == 32'h0000_0000)
    else $error("unprivileged access was not refused");

  AST_ICACHE_SUPPORT: assert property (
    s_read_geom ##0 cur_icache |=> cp_rsp.rdata[31:28] == 4'h2)
    else $error("instruction cache support bits wrong");

  AST_DCACHE_SUPPORT: assert property (
    s_read_geom ##0 !cur_icache |=> cp_rsp.rdata[31:28] == 4'h7)
    else $error("data cache support bits wrong");

  AST_SET_COUNT: assert property (
    s_read_geom |=> cp_rsp.rdata[27:13] == sets_expect && !cp_rsp.refused)
    else $error("set count does not match cache size");

  AST_WAYS_LINE: assert property (
    s_read_geom |=> cp_rsp.rdata[12:3] == 10'h003 && cp_rsp.rdata[2:0] == 3'h1)
    else $error("associativity or line length wrong");

  AST_HIERARCHY: assert property (
    cp_req.valid && cp_req.priv && !cp_req.write && hit_hier
    |=> cp_rsp.rdata == 32'h0920_0003)
    else $error("hierarchy register value wrong");

  AST_AUX_ZERO: assert property (
    cp_req.valid && cp_req.priv && hit_aux
    |=> cp_rsp.rdata == 32'h0000_0000 && cp_rsp.refused == $past(cp_req.write))
    else $error("auxiliary register not read-only zero");

  AST_SEL_FOLLOWS: assert property (
    s_write_sel(1'b1) ##1 (s_read_geom ##0
      cp_req.nonsecure == $past(cp_req.nonsecure))
    |=> cp_rsp.rdata[31:28] == 4'h2)
    else $error("geometry did not follow picker write");

  AST_SEL_DATA: assert property (
    s_write_sel(1'b0) ##1 (s_read_geom ##0
      cp_req.nonsecure == $past(cp_req.nonsecure))
    |=> cp_rsp.rdata[31:28] == 4'h7)
    else $error("writing zero did not select the data cache");

  AST_BANKED: assert property (
    sel_wr && !cp_req.nonsecure |=> $stable(ns_icache))
    else $error("secure picker write disturbed non-secure copy");

  AST_LEVEL_RAZ: assert property (
    cp_req.valid && cp_req.priv && !cp_req.write && hit_sel
    |=> cp_rsp.rdata[31:1] == 31'h0000_0000)
    else $error("picker level or spare bits not zero");

  // Support pattern, hierarchy fields, picker write acceptance and refusals, checked one concern at a time
  sequence s_read_hier;
    cp_req.valid && cp_req.priv && !cp_req.write && hit_hier;
  endsequence

  sequence s_write_id;
    cp_req.valid && cp_req.priv && cp_req.write && (hit_geom || hit_hier || hit_aux);
  endsequence

  AST_SUPPORT_PATTERN: assert property (
    s_read_geom
    |=> cp_rsp.rdata[31:28] == 4'h2 || cp_rsp.rdata[31:28] == 4'h7)
    else $error("geometry support bits hold neither cache pattern");

  AST_HIER_L1_SPLIT: assert property (
    s_read_hier
    |=> cp_rsp.rdata[2:0] == 3'h3 && !cp_rsp.refused)
    else $error("hierarchy level one type is not split caches");

  AST_HIER_UPPER_NONE: assert property (
    s_read_hier
    |=> cp_rsp.rdata[20:3] == 18'h0_0000)
    else $error("hierarchy reports a cache above level one");

  AST_ID_WRITE_REFUSED: assert property (
    s_write_id
    |=> cp_rsp.ack && cp_rsp.refused && cp_rsp.rdata == 32'h0000_0000)
    else $error("write to an identification register was not refused");

  AST_SEL_WRITE_OK: assert property (
    cp_req.valid && cp_req.priv && cp_req.write && hit_sel
    |=> cp_rsp.ack && !cp_rsp.refused && cp_rsp.rdata == 32'h0000_0000)
    else $error("privileged picker write was not accepted");

  AST_UNMAPPED_REFUSED: assert property (
    cp_req.valid && cp_req.priv && !mapped
    |=> cp_rsp.ack && cp_rsp.refused && cp_rsp.rdata == 32'h0000_0000)
    else $error("unmapped coprocessor access was not refused");

  // An accepted write changes only the copy of its own security state; without one, neither copy changes
  AST_BANKED_NS: assert property (
    sel_wr && cp_req.nonsecure
    |=> $stable(sec_icache))
    else $error("non-secure picker write disturbed secure copy");

  AST_SEC_STORE: assert property (
    sec_wr
    |=> sec_icache == $past(cp_req.wdata[0]))
    else $error("secure picker copy did not take written bit");

  AST_NS_STORE: assert property (
    ns_wr
    |=> ns_icache == $past(cp_req.wdata[0]))
    else $error("non-secure picker copy did not take written bit");

  AST_PICKER_HOLD: assert property (
    !sel_wr
    |=> $stable(sec_icache) && $stable(ns_icache))
    else $error("picker copy changed without an accepted write");

  AST_PICKER_READ_OWN: assert property (
    cp_req.valid && cp_req.priv && !cp_req.write && hit_sel && cp_req.nonsecure
    |=> cp_rsp.rdata[0] == $past(ns_icache))
    else $error("non-secure picker read did not return its own copy");

  // Every request is answered once, one cycle later, and nothing else
  AST_ACK_PULSE: assert property (
    cp_req.valid
    |=> cp_rsp.ack)
    else $error("request was not answered one cycle later");

  AST_NO_STRAY_ACK: assert property (
    !cp_req.valid
    |=> !cp_rsp.ack && !cp_rsp.refused)
    else $error("answer appeared without a request");

endmodule // cache_id_regs
`default_nettype wire

//--- cache_identification_regs_tb_top.sv
/*
  Self-checking bench for the cache identification register bank.
  Three builds (16, 32 and 64KB) share one request stream.
  Assumes cache_id_pkg is compiled before this file.
*/
`default_nettype none
module cache_identification_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  cache_id_pkg::cp_req_t req = '0;
  cache_id_pkg::cp_rsp_t r16, r32, r64;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #20 clk_sys = ~clk_sys;

  cache_id_regs #(.CACHE_SIZE_KB(16)) uut_16 (
    .clk_sys(clk_sys), .rst_n(rst_n), .cp_req(req), .cp_rsp(r16));
  cache_id_regs #(.CACHE_SIZE_KB(32)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .cp_req(req), .cp_rsp(r32));
  cache_id_regs #(.CACHE_SIZE_KB(64)) uut_64 (
    .clk_sys(clk_sys), .rst_n(rst_n), .cp_req(req), .cp_rsp(r64));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // The whole run needs well under a hundred cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_errors++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] geo(input logic ic, input int kb);
    logic [14:0] sets;
    sets = (kb == 16) ? 15'h007F : (kb == 32) ? 15'h00FF : 15'h01FF;
    return {(ic ? 4'h2 : 4'h7), sets, 10'h003, 3'h1};
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One request, held for exactly one taking edge; answer sampled just after it
  task automatic acc(input logic wr, pv, ns, input logic [2:0] o1, o2, input logic [31:0] wd);
    @(posedge clk_sys);
    req <= '{1'b1, wr, pv, ns, o1, 4'h0, 4'h0, o2, wd};
    @(posedge clk_sys);
    req.valid <= 1'b0;
    #1;
  endtask

  task automatic see(input string nm, input logic rf, input logic [31:0] e16, e32, e64);
    chk({nm, " ack"}, 32'h0000_0007, {29'h0, r16.ack, r32.ack, r64.ack});
    chk({nm, " refused"}, {29'h0, rf, rf, rf}, {29'h0, r16.refused, r32.refused, r64.refused});
    chk({nm, " data16"}, e16, r16.rdata);
    chk({nm, " data32"}, e32, r32.rdata);
    chk({nm, " data64"}, e64, r64.rdata);
  endtask

  task automatic see1(input string nm, input logic rf, input logic [31:0] e);
    see(nm, rf, e, e, e);
  endtask

  task automatic seeg(input string nm, input logic ic);
    see(nm, 1'b0, geo(ic, 16), geo(ic, 32), geo(ic, 64));
  endtask

  task automatic test_ids();
    #1;
    chk("idle ack", 32'h0, {31'h0, r32.ack});
    for (int ns = 0; ns < 2; ns++) begin
      acc(1'b0, 1'b1, ns[0], 3'h1, 3'h0, 32'h0);
      seeg("geometry default", 1'b0);
      acc(1'b0, 1'b1, ns[0], 3'h1, 3'h1, 32'h0);
      see1("hierarchy", 1'b0, 32'h0920_0003);
      acc(1'b0, 1'b1, ns[0], 3'h1, 3'h7, 32'h0);
      see1("aux", 1'b0, 32'h0000_0000);
    end
    $display("test_ids done");
  endtask

  task automatic test_picker();
    acc(1'b1, 1'b1, 1'b0, 3'h2, 3'h0, 32'hFFFF_FFFF);
    see1("picker write", 1'b0, 32'h0000_0000);
    acc(1'b0, 1'b1, 1'b0, 3'h2, 3'h0, 32'h0);
    see1("picker secure", 1'b0, 32'h0000_0001);
    acc(1'b0, 1'b1, 1'b1, 3'h2, 3'h0, 32'h0);
    see1("picker nonsecure", 1'b0, 32'h0000_0000);
    acc(1'b0, 1'b1, 1'b0, 3'h1, 3'h0, 32'h0);
    seeg("geometry secure", 1'b1);
    acc(1'b0, 1'b1, 1'b1, 3'h1, 3'h0, 32'h0);
    seeg("geometry nonsecure", 1'b0);
    acc(1'b1, 1'b1, 1'b0, 3'h2, 3'h0, 32'hFFFF_FFFE);
    acc(1'b0, 1'b1, 1'b0, 3'h1, 3'h0, 32'h0);
    seeg("geometry cleared", 1'b0);
    $display("test_picker done");
  endtask

  task automatic test_back_to_back();
    @(posedge clk_sys);
    req <= '{1'b1, 1'b1, 1'b1, 1'b1, 3'h2, 4'h0, 4'h0, 3'h0, 32'h0000_0001};
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, 1'b1, 1'b1, 3'h1, 4'h0, 4'h0, 3'h0, 32'h0000_0000};
    #1;
    see1("b2b write", 1'b0, 32'h0000_0000);
    @(posedge clk_sys);
    req <= '{1'b1, 1'b1, 1'b1, 1'b0, 3'h2, 4'h0, 4'h0, 3'h0, 32'h0000_0001};
    #1;
    seeg("b2b geometry", 1'b1);
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, 1'b1, 1'b0, 3'h1, 4'h0, 4'h0, 3'h0, 32'h0000_0000};
    #1;
    see1("b2b secure write", 1'b0, 32'h0000_0000);
    @(posedge clk_sys);
    req <= '{1'b1, 1'b1, 1'b1, 1'b0, 3'h2, 4'h0, 4'h0, 3'h0, 32'h0000_0000};
    #1;
    seeg("b2b secure icache", 1'b1);
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, 1'b1, 1'b0, 3'h1, 4'h0, 4'h0, 3'h0, 32'h0000_0000};
    #1;
    see1("b2b secure clear", 1'b0, 32'h0000_0000);
    @(posedge clk_sys);
    req.valid <= 1'b0;
    #1;
    seeg("b2b secure dcache", 1'b0);
    $display("test_back_to_back done");
  endtask

  task automatic test_refusal();
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 1'b0, 1'b0, (i == 3) ? 3'h2 : 3'h1, (i == 1) ? 3'h1 : (i == 2) ? 3'h7 : 3'h0,
          32'h0);
      see1("unprivileged read", 1'b1, 32'h0000_0000);
    end
    acc(1'b1, 1'b0, 1'b1, 3'h2, 3'h0, 32'h0000_0000);
    see1("unprivileged write", 1'b1, 32'h0000_0000);
    acc(1'b0, 1'b1, 1'b1, 3'h2, 3'h0, 32'h0);
    see1("picker kept", 1'b0, 32'h0000_0001);
    acc(1'b1, 1'b1, 1'b0, 3'h1, 3'h0, 32'h0000_0001);
    see1("geometry write", 1'b1, 32'h0000_0000);
    acc(1'b1, 1'b1, 1'b0, 3'h1, 3'h7, 32'h0000_0001);
    see1("aux write", 1'b1, 32'h0000_0000);
    acc(1'b0, 1'b1, 1'b0, 3'h3, 3'h0, 32'h0);
    see1("unmapped read", 1'b1, 32'h0000_0000);
    acc(1'b0, 1'b1, 1'b0, 3'h2, 3'h0, 32'h0);
    see1("secure picker kept", 1'b0, 32'h0000_0000);
    $display("test_refusal done");
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    test_ids();
    test_picker();
    test_back_to_back();
    test_refusal();
    report_and_stop();
  end
endmodule // cache_identification_regs_tb_top
`default_nettype wire

//--- cache_sel_bank.sv
/*
  One copy of the cache picker selection bit. The main bank keeps one
  instance per security state. Assumes the write strobe is already
  qualified by privilege, address and security state.
*/
`default_nettype none
`include "cache_id_consts.svh"

module cache_sel_bank (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic wr_bit,
  output logic icache_not_dcache
);

  logic sel_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sel_r <= `CID_SEL_RESET;
    end else if (wr_en) begin
      sel_r <= wr_bit;
    end
  end

  assign icache_not_dcache = sel_r;

endmodule // cache_sel_bank
`default_nettype wire
